// ---- verilog/effects_chain.sv ----
// Audio effects chain: mixer, surround, bass, equalizer, level control, Wishbone registers
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module effects_chain (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Sample stream from the source switch
	input wire logic sample_valid,
	input wire effects_pkg::stereo_t main_in,
	input wire effects_pkg::stereo_t mix_in,
	// Processed stream
	output effects_pkg::stereo_t out_sample,
	output logic out_valid
);
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_MIX = 3'b001,
		PH_SURR = 3'b010,
		PH_BASS = 3'b011,
		PH_EQ = 3'b100,
		PH_EQ_SUM = 3'b101,
		PH_ALC = 3'b110
	} phase_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		effects_pkg::ctrl_t ctrl;
		logic [9:0] gain_main;
		logic [9:0] gain_aux;
		logic [2:0] width;
		logic [2:0] cutoff;
		logic [6:0] orig_lvl;
		logic [6:0] bass_lvl;
		logic [4:0][6:0] graphic_equalizer;
		logic [15:0] thresh;
		logic [1:0] maxg;
		logic [19:0] attack;
		logic [19:0] decay;
		logic [6:0][4:0][19:0] coef;
		logic [6:0][1:0][63:0] hist;
		phase_t phase;
		logic [2:0] sec;
		logic ch;
		effects_pkg::sample_t [1:0] cur;
		effects_pkg::sample_t [1:0] aux;
		effects_pkg::sample_t [1:0] eq_in;
		logic [1:0][39:0] acc;
		effects_pkg::sample_t surr_prev;
		logic [31:0] bass_lp;
		logic [1:0][31:0] hp_lp;
		effects_pkg::stereo_t out;
		logic out_valid;
	} chain_state_t;

	chain_state_t st;
	chain_state_t next_st;

	effects_pkg::sample_t eq_x;
	effects_pkg::sample_t eq_y;
	effects_pkg::hist_t eq_hist;
	effects_pkg::stereo_t alc_out;
	logic [9:0] alc_gain;
	logic [15:0] alc_level;

	function automatic logic is_coef(input logic [11:0] wa);
		return wa >= effects_pkg::COEF_BASE && wa < effects_pkg::COEF_END && wa[4:2] < 3'h5;
	endfunction : is_coef

	assign eq_hist = effects_pkg::hist_t'(st.hist[st.sec][st.ch]);
	assign eq_x = st.ctrl.eq_sel == effects_pkg::EQ_GRAPHIC ? st.eq_in[st.ch] : st.cur[st.ch];

	effects_biquad u_biquad (
		.coef(st.coef[st.sec]),
		.hist(eq_hist),
		.x(eq_x),
		.y(eq_y)
	);

	effects_level_control u_level (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.apply(st.phase == PH_ALC),
		.enable(st.ctrl.alc_en),
		.thresh(st.thresh),
		.max_sel(st.maxg),
		.attack(st.attack),
		.decay(st.decay),
		.in_sample(effects_pkg::stereo_t'(st.cur)),
		.out_sample(alc_out),
		.gain_code(alc_gain),
		.level(alc_level)
	);

	always_comb begin
		logic [11:0] wa;
		logic [31:0] rd;
		logic [31:0] wv;
		logic [2:0] last;
		logic [9:0] gm;
		logic [9:0] ga;
		logic [16:0] alpha;
		logic signed [47:0] t0;
		logic signed [47:0] t1;
		logic signed [47:0] syn;
		logic signed [47:0] y;
		next_st = st;
		wa = {adr_i[11:2], 2'b00};
		rd = '0;
		wv = '0;
		last = '0;
		gm = st.gain_main > effects_pkg::MIX_GAIN_MAX ? effects_pkg::MIX_GAIN_MAX : st.gain_main;
		ga = st.gain_aux > effects_pkg::MIX_GAIN_MAX ? effects_pkg::MIX_GAIN_MAX : st.gain_aux;
		alpha = effects_pkg::bass_alpha(st.cutoff);
		t0 = '0;
		t1 = '0;
		syn = '0;
		y = '0;

		// Register readback; unmapped words read zero
		case (wa)
			effects_pkg::REG_CTRL: rd[8:0] = st.ctrl;
			effects_pkg::REG_MIXER: begin
				rd[effects_pkg::MIX_MAIN_LSB +: 10] = st.gain_main;
				rd[effects_pkg::MIX_AUX_LSB +: 10] = st.gain_aux;
			end
			effects_pkg::REG_SHAPE: begin
				rd[effects_pkg::SURR_WIDTH_LSB +: 3] = st.width;
				rd[effects_pkg::BASS_CUT_LSB +: 3] = st.cutoff;
				rd[effects_pkg::BASS_ORIG_LSB +: 7] = st.orig_lvl;
				rd[effects_pkg::BASS_LEVEL_LSB +: 7] = st.bass_lvl;
			end
			effects_pkg::REG_GEQ_LO: begin
				for (int k = 0; k < 4; k++) rd[effects_pkg::GEQ_BAND_STRIDE * k +: 7] = st.graphic_equalizer[k];
			end
			effects_pkg::REG_GEQ_HI: rd[6:0] = st.graphic_equalizer[4];
			effects_pkg::REG_ALC_THRESH: begin
				rd[15:0] = st.thresh;
				rd[effects_pkg::ALC_MAXG_LSB +: 2] = st.maxg;
			end
			effects_pkg::REG_ALC_ATTACK: rd[19:0] = st.attack;
			effects_pkg::REG_ALC_DECAY: rd[19:0] = st.decay;
			effects_pkg::REG_STATUS: begin
				rd[15:0] = alc_level;
				rd[effects_pkg::STAT_GAIN_LSB +: 10] = alc_gain;
			end
			default: begin
				if (is_coef(wa)) rd[19:0] = st.coef[wa[7:5]][wa[4:2]];
			end
		endcase
		wv = effects_pkg::byte_merge(rd, dat_i, sel_i);

		// Classic Wishbone: one wait state, ack for a single cycle
		next_st.ack = cyc_i && stb_i && !st.ack;
		if (cyc_i && stb_i && !st.ack) begin
			next_st.dat = rd;
			if (we_i) begin
				case (wa)
					effects_pkg::REG_CTRL: next_st.ctrl = effects_pkg::ctrl_t'(wv[8:0]);
					effects_pkg::REG_MIXER: begin
						next_st.gain_main = wv[effects_pkg::MIX_MAIN_LSB +: 10];
						next_st.gain_aux = wv[effects_pkg::MIX_AUX_LSB +: 10];
					end
					effects_pkg::REG_SHAPE: begin
						next_st.width = wv[effects_pkg::SURR_WIDTH_LSB +: 3];
						next_st.cutoff = wv[effects_pkg::BASS_CUT_LSB +: 3];
						next_st.orig_lvl = wv[effects_pkg::BASS_ORIG_LSB +: 7];
						next_st.bass_lvl = wv[effects_pkg::BASS_LEVEL_LSB +: 7];
					end
					effects_pkg::REG_GEQ_LO: begin
						for (int k = 0; k < 4; k++) begin
							next_st.graphic_equalizer[k] = wv[effects_pkg::GEQ_BAND_STRIDE * k +: 7];
						end
					end
					effects_pkg::REG_GEQ_HI: next_st.graphic_equalizer[4] = wv[6:0];
					effects_pkg::REG_ALC_THRESH: begin
						next_st.thresh = wv[15:0];
						next_st.maxg = wv[effects_pkg::ALC_MAXG_LSB +: 2];
					end
					effects_pkg::REG_ALC_ATTACK: next_st.attack = wv[19:0];
					effects_pkg::REG_ALC_DECAY: next_st.decay = wv[19:0];
					default: begin
						if (is_coef(wa)) next_st.coef[wa[7:5]][wa[4:2]] = wv[19:0];
					end
				endcase
			end
		end

		// Stage sequencer, one sample pair at a time
		next_st.out_valid = 1'b0;
		case (st.phase)
			PH_IDLE: begin
				if (sample_valid) begin
					if (st.ctrl.chain_en) begin
						next_st.cur = main_in;
						next_st.aux = mix_in;
						next_st.phase = PH_MIX;
					end else begin
						// Routed but not enabled: silence keeps the frame rate
						next_st.out = '0;
						next_st.out_valid = 1'b1;
					end
				end
			end
			PH_MIX: begin
				if (st.ctrl.mix_en) begin
					for (int c = 0; c < 2; c++) begin
						t0 = st.cur[c] * $signed({1'b0, gm}) + st.aux[c] * $signed({1'b0, ga});
						next_st.cur[c] = effects_pkg::sat16(t0 >>> 8);
					end
				end
				next_st.phase = PH_SURR;
			end
			PH_SURR: begin
				next_st.surr_prev = st.cur[1];
				if (st.ctrl.surr_en) begin
					t0 = st.cur[1];
					if (st.ctrl.stereo_in) begin
						t0 = (t0 + st.cur[0]) >>> 1;
						t1 = st.cur[1];
						t1 = (t1 - st.cur[0]) >>> 1;
					end else begin
						// Mono source: side signal made from the sample slope
						t1 = st.cur[1];
						t1 = (t1 - st.surr_prev) >>> 1;
					end
					t1 = (t1 * (48'sd8 + $signed({45'h0, st.width}))) >>> 3;
					next_st.cur[1] = effects_pkg::sat16(t0 + t1);
					next_st.cur[0] = effects_pkg::sat16(t0 - t1);
				end
				next_st.phase = PH_BASS;
			end
			PH_BASS: begin
				if (st.ctrl.bass_en) begin
					t0 = st.cur[1];
					t0 = (t0 + st.cur[0]) <<< 15;
					t1 = $signed(st.bass_lp);
					next_st.bass_lp = 32'(t1 + (((t0 - t1) * $signed({1'b0, alpha})) >>> 16));
					t1 = t1 >>> 16;
					// Rectified lows add harmonics the speaker can reproduce
					syn = t1 + ((t1 < 0 ? -t1 : t1) >>> 1);
					for (int c = 0; c < 2; c++) begin
						y = (st.cur[c] * $signed({1'b0, st.orig_lvl})
							+ syn * $signed({1'b0, st.bass_lvl})) >>> 6;
						if (st.ctrl.hpf_en) begin
							t0 = y <<< 16;
							t1 = $signed(st.hp_lp[c]);
							next_st.hp_lp[c] = 32'(t1 + (((t0 - t1) * $signed({1'b0, alpha})) >>> 16));
							y = y - (t1 >>> 16);
						end
						next_st.cur[c] = effects_pkg::sat16(y);
					end
				end
				next_st.sec = '0;
				next_st.ch = 1'b0;
				next_st.acc = '0;
				next_st.eq_in = next_st.cur;
				next_st.phase = st.ctrl.eq_sel == effects_pkg::EQ_OFF ? PH_ALC : PH_EQ;
			end
			PH_EQ: begin
				case (st.ctrl.eq_sel)
					effects_pkg::EQ_PARAM: last = 3'(effects_pkg::PEQ_SECTIONS - 1);
					effects_pkg::EQ_TONE: last = 3'(effects_pkg::TONE_SECTIONS - 1);
					default: last = 3'(effects_pkg::GEQ_BANDS - 1);
				endcase
				next_st.hist[st.sec][st.ch] = {eq_hist.y1, eq_y, eq_hist.x1, eq_x};
				if (st.ctrl.eq_sel == effects_pkg::EQ_GRAPHIC) begin
					t0 = eq_y * $signed({1'b0, effects_pkg::db_to_lin(
						10'($signed({3'h0, st.graphic_equalizer[st.sec]}) - $signed({3'h0, effects_pkg::GEQ_RST})))});
					next_st.acc[st.ch] = 40'($signed(st.acc[st.ch]) + t0);
				end else begin
					next_st.cur[st.ch] = eq_y;
				end
				next_st.ch = ~st.ch;
				if (st.ch) begin
					next_st.sec = st.sec + 3'h1;
					if (st.sec == last) begin
						next_st.phase = st.ctrl.eq_sel == effects_pkg::EQ_GRAPHIC ? PH_EQ_SUM : PH_ALC;
					end
				end
			end
			PH_EQ_SUM: begin
				// Band sum scaled by one fifth so flat bands give unity
				for (int c = 0; c < 2; c++) begin
					t0 = $signed(st.acc[c]);
					t0 = ((t0 >>> 14) * effects_pkg::GEQ_NORM) >>> 16;
					next_st.cur[c] = effects_pkg::sat16(t0);
				end
				next_st.phase = PH_ALC;
			end
			PH_ALC: begin
				next_st.out = alc_out;
				next_st.out_valid = 1'b1;
				next_st.phase = PH_IDLE;
			end
			default: next_st.phase = PH_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.gain_main <= effects_pkg::MIX_MAIN_RST;
			st.gain_aux <= effects_pkg::MIX_AUX_RST;
			st.orig_lvl <= effects_pkg::BASS_ORIG_RST;
			st.bass_lvl <= effects_pkg::BASS_LEVEL_RST;
			st.graphic_equalizer <= {5{effects_pkg::GEQ_RST}};
			st.thresh <= effects_pkg::ALC_THRESH_RST;
			st.attack <= effects_pkg::ALC_ATTACK_RST;
			st.decay <= effects_pkg::ALC_DECAY_RST;
			st.coef <= {7{effects_pkg::COEF_FLAT}};
		end else begin
			st <= next_st;
		end
	end

	assign dat_o = st.dat;
	assign ack_o = st.ack;
	assign out_sample = st.out;
	assign out_valid = st.out_valid;
endmodule : effects_chain

// ---- verilog/effects_pkg.sv ----
// Shared types, register map, field layout and constants of the audio effects chain
package effects_pkg;
	typedef logic signed [15:0] sample_t;
	typedef struct packed {
		sample_t l;
		sample_t r;
	} stereo_t;
	// Index 0 b0, 1 b1, 2 b2, 3 a1, 4 a2
	typedef logic [4:0][19:0] coef_t;
	typedef struct packed {
		sample_t y2;
		sample_t y1;
		sample_t x2;
		sample_t x1;
	} hist_t;
	typedef enum logic [1:0] {
		EQ_OFF = 2'b00,
		EQ_PARAM = 2'b01,
		EQ_TONE = 2'b10,
		EQ_GRAPHIC = 2'b11
	} eq_mode_t;
	typedef struct packed {
		eq_mode_t eq_sel;
		logic stereo_in;
		logic hpf_en;
		logic alc_en;
		logic bass_en;
		logic surr_en;
		logic mix_en;
		logic chain_en;
	} ctrl_t;

	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_MIXER = 12'h004;
	localparam logic [11:0] REG_SHAPE = 12'h008;
	localparam logic [11:0] REG_GEQ_LO = 12'h00C;
	localparam logic [11:0] REG_GEQ_HI = 12'h010;
	localparam logic [11:0] REG_ALC_THRESH = 12'h014;
	localparam logic [11:0] REG_ALC_ATTACK = 12'h018;
	localparam logic [11:0] REG_ALC_DECAY = 12'h01C;
	localparam logic [11:0] REG_STATUS = 12'h020;
	localparam logic [11:0] COEF_BASE = 12'h100;
	localparam logic [11:0] COEF_END = 12'h1E0;

	localparam int MIX_MAIN_LSB = 0;
	localparam int MIX_AUX_LSB = 16;
	localparam int SURR_WIDTH_LSB = 0;
	localparam int BASS_CUT_LSB = 4;
	localparam int BASS_ORIG_LSB = 8;
	localparam int BASS_LEVEL_LSB = 16;
	localparam int GEQ_BAND_STRIDE = 8;
	localparam int ALC_MAXG_LSB = 16;
	localparam int STAT_GAIN_LSB = 16;

	localparam logic [9:0] MIX_MAIN_RST = 10'h100;
	localparam logic [9:0] MIX_AUX_RST = 10'h000;
	localparam logic [9:0] MIX_GAIN_MAX = 10'h200;
	localparam logic [6:0] GEQ_RST = 7'h2F;
	localparam logic [6:0] BASS_ORIG_RST = 7'h40;
	localparam logic [6:0] BASS_LEVEL_RST = 7'h20;
	localparam logic [15:0] ALC_THRESH_RST = 16'h2000;
	localparam logic [19:0] ALC_ATTACK_RST = 20'h00020;
	localparam logic [19:0] ALC_DECAY_RST = 20'h00040;
	localparam logic [19:0] COEF_B0_FLAT = 20'h20000;
	localparam coef_t COEF_FLAT = {80'h0, COEF_B0_FLAT};
	localparam int COEF_FRAC = 17;

	localparam int PEQ_SECTIONS = 7;
	localparam int TONE_SECTIONS = 2;
	localparam int GEQ_BANDS = 5;
	localparam int GEQ_NORM = 13107;
	localparam int QDB_PER_OCTAVE = 24;
	localparam int QDB_FLOOR = 384;
	localparam int LIN_ONE = 16384;
	localparam int LIN_SLOPE = 683;

	// Level control rates, in 2^-20 dB per sample at the stream rate
	localparam longint FS_HZ = 48000;
	localparam longint DB_ONE = 1048576;
	localparam logic [19:0] ATTACK_MIN = 20'((5 * DB_ONE) / (100 * FS_HZ) + 1);
	localparam logic [19:0] ATTACK_MAX = 20'((200 * DB_ONE) / FS_HZ);
	localparam logic [19:0] DECAY_MIN = 20'((8 * DB_ONE) / (10 * FS_HZ) + 1);
	localparam logic [19:0] DECAY_MAX = 20'((3200 * DB_ONE) / FS_HZ);
	localparam logic signed [27:0] ALC_GAIN_6DB = 28'sh0600000;
	localparam logic signed [27:0] ALC_GAIN_12DB = 28'sh0C00000;
	localparam logic signed [27:0] ALC_GAIN_MIN = -28'sh6000000;

	function automatic sample_t sat16(input logic signed [47:0] v);
		if (v > 48'sh7FFF) return 16'sh7FFF;
		if (v < -48'sh8000) return 16'sh8000;
		return v[15:0];
	endfunction : sat16

	// Quarter-dB code to linear gain, 1.0 = 16384, piecewise linear per octave
	function automatic logic [17:0] db_to_lin(input logic signed [9:0] q);
		int n;
		int r;
		int m;
		n = (int'(q) + QDB_FLOOR) / QDB_PER_OCTAVE - QDB_FLOOR / QDB_PER_OCTAVE;
		r = int'(q) + QDB_FLOOR - (n + QDB_FLOOR / QDB_PER_OCTAVE) * QDB_PER_OCTAVE;
		m = LIN_ONE + r * LIN_SLOPE;
		if (n >= 0) return 18'(m <<< n);
		return 18'(m >>> (-n));
	endfunction : db_to_lin

	// One-pole smoothing factor, Q16, cutoff steps from 80 Hz to 225 Hz
	function automatic logic [16:0] bass_alpha(input logic [2:0] c);
		case (c)
			3'h0: return 17'h002AE;
			3'h1: return 17'h0035A;
			3'h2: return 17'h00430;
			3'h3: return 17'h00507;
			3'h4: return 17'h005DD;
			3'h5: return 17'h006B4;
			default: return 17'h0078A;
		endcase
	endfunction : bass_alpha

	function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) r[8 * i +: 8] = new_v[8 * i +: 8];
		end
		return r;
	endfunction : byte_merge
endpackage : effects_pkg

// ---- verilog/effects_biquad.sv ----
// Second-order IIR section, Direct Form 1, five coefficients
`timescale 1ns/1ps
module effects_biquad (
	// Section coefficients and history
	input wire effects_pkg::coef_t coef,
	input wire effects_pkg::hist_t hist,
	// Sample
	input wire effects_pkg::sample_t x,
	output effects_pkg::sample_t y
);
	always_comb begin
		logic signed [47:0] acc;
		acc = '0;
		acc = $signed(coef[0]) * x + $signed(coef[1]) * hist.x1
			+ $signed(coef[2]) * hist.x2 - $signed(coef[3]) * hist.y1
			- $signed(coef[4]) * hist.y2;
		y = effects_pkg::sat16(acc >>> effects_pkg::COEF_FRAC);
	end
endmodule : effects_biquad

// ---- verilog/effects_level_control.sv ----
// Automatic level control: compressor, expander and limiter at the end of the chain
`timescale 1ns/1ps
module effects_level_control (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Settings
	input wire logic apply,
	input wire logic enable,
	input wire logic [15:0] thresh,
	input wire logic [1:0] max_sel,
	input wire logic [19:0] attack,
	input wire logic [19:0] decay,
	// Samples and state
	input wire effects_pkg::stereo_t in_sample,
	output effects_pkg::stereo_t out_sample,
	output logic [9:0] gain_code,
	output logic [15:0] level
);
	typedef struct packed {
		logic signed [27:0] gain;
		logic [15:0] level;
	} alc_state_t;
	alc_state_t st;
	alc_state_t next_st;

	always_comb begin
		logic [17:0] lin;
		logic signed [47:0] t;
		logic signed [27:0] gmax;
		logic [19:0] a_step;
		logic [19:0] d_step;
		effects_pkg::sample_t yl;
		effects_pkg::sample_t yr;
		logic [15:0] pk;
		lin = '0;
		t = '0;
		gmax = '0;
		a_step = '0;
		d_step = '0;
		yl = '0;
		yr = '0;
		pk = '0;
		next_st = st;
		lin = effects_pkg::db_to_lin(10'(st.gain >>> 18));
		t = in_sample.l * $signed({1'b0, lin});
		yl = effects_pkg::sat16(t >>> 14);
		t = in_sample.r * $signed({1'b0, lin});
		yr = effects_pkg::sat16(t >>> 14);
		out_sample = enable ? {yl, yr} : in_sample;
		pk = yl[15] ? ~yl : yl;
		if (yr[15] ? (~yr > pk) : (yr > pk)) pk = yr[15] ? ~yr : yr;
		case (max_sel)
			2'h0: gmax = '0;
			2'h1: gmax = effects_pkg::ALC_GAIN_6DB;
			default: gmax = effects_pkg::ALC_GAIN_12DB;
		endcase
		a_step = attack < effects_pkg::ATTACK_MIN ? effects_pkg::ATTACK_MIN :
			(attack > effects_pkg::ATTACK_MAX ? effects_pkg::ATTACK_MAX : attack);
		d_step = decay < effects_pkg::DECAY_MIN ? effects_pkg::DECAY_MIN :
			(decay > effects_pkg::DECAY_MAX ? effects_pkg::DECAY_MAX : decay);
		if (apply) begin
			// Level is measured after the gain, so expansion stops at the threshold
			next_st.level = pk > st.level ? pk : st.level - (st.level >> 8);
			if (!enable) begin
				next_st.gain = '0;
			end else if (st.level > thresh) begin
				next_st.gain = st.gain - $signed({8'h0, a_step});
				if (next_st.gain < effects_pkg::ALC_GAIN_MIN) next_st.gain = effects_pkg::ALC_GAIN_MIN;
			end else begin
				next_st.gain = st.gain + $signed({8'h0, d_step});
			end
			if (enable && next_st.gain > gmax) next_st.gain = gmax;
		end
		gain_code = 10'(st.gain >>> 18);
		level = st.level;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) st <= '0;
		else st <= next_st;
	end
endmodule : effects_level_control

// ---- verification/effects_chain_props.sv ----
// Port-level assertions for the audio effects chain
`timescale 1ns/1ps
module effects_chain_props (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Streams
	input wire logic sample_valid,
	input wire effects_pkg::stereo_t main_in,
	input wire effects_pkg::stereo_t mix_in,
	input wire effects_pkg::stereo_t out_sample,
	input wire logic out_valid
);
	logic [8:0] ctrl;
	logic take;
	assign take = cyc_i && stb_i && !ack_o;
	// Shadow of the control word, updated when a write is taken
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) ctrl <= 9'h000;
		else if (take && we_i && adr_i[11:2] == 10'h000) begin
			if (sel_i[0]) ctrl[7:0] <= dat_i[7:0];
			if (sel_i[1]) ctrl[8] <= dat_i[8];
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	ack_answer_a: assert property (take |=> ack_o) else $error("no ack after request");
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than a cycle");
	unmapped_zero_a: assert property (take && !we_i && adr_i[11:9] != 3'h0 |=> dat_o == 32'h0)
		else $error("unmapped read not zero");
	mute_off_a:
		assert property (sample_valid && !ctrl[0] |=> out_valid && out_sample == 32'h0)
		else $error("audio left a disabled chain");
	eq_off_lat_a:
		assert property (sample_valid && ctrl[0] && ctrl[8:7] == 2'h0
			|=> !out_valid [*4] ##1 out_valid) else $error("five stage latency wrong");
	param_lat_a:
		assert property (sample_valid && ctrl[0] && ctrl[8:7] == 2'h1 |-> ##19 out_valid)
		else $error("parametric latency wrong");
	tone_lat_a:
		assert property (sample_valid && ctrl[0] && ctrl[8:7] == 2'h2 |-> ##9 out_valid)
		else $error("tone latency wrong");
	graphic_lat_a:
		assert property (sample_valid && ctrl[0] && ctrl[8:7] == 2'h3 |-> ##16 out_valid)
		else $error("graphic latency wrong");
	out_hold_a: assert property (!out_valid |-> $stable(out_sample))
		else $error("output changed without valid");
endmodule : effects_chain_props

bind effects_chain effects_chain_props props (.sys_clk(sys_clk), .rst_n(rst_n), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .sample_valid(sample_valid), .main_in(main_in), .mix_in(mix_in),
	.out_sample(out_sample), .out_valid(out_valid));

// ---- verification/source_switch_model.sv ----
// Source switch model feeding the chain and collecting processed pairs
`timescale 1ns/1ps
module source_switch_model (
	// Clock
	input wire logic sys_clk,
	// Samples towards the chain
	output logic sample_valid,
	output effects_pkg::stereo_t main_in,
	output effects_pkg::stereo_t mix_in,
	// Processed samples back
	input wire effects_pkg::stereo_t out_sample,
	input wire logic out_valid
);
	initial begin
		sample_valid = 1'h0;
		main_in = 32'h0;
		mix_in = 32'h0;
	end
	// Between pairs the lines carry inverted junk, not the last pair
	task automatic send(input effects_pkg::stereo_t m, input effects_pkg::stereo_t x,
		output effects_pkg::stereo_t got);
		int n;
		@(posedge sys_clk);
		sample_valid <= 1'h1;
		main_in <= m;
		mix_in <= x;
		@(posedge sys_clk);
		sample_valid <= 1'h0;
		main_in <= ~m;
		mix_in <= ~x;
		n = 0;
		while (out_valid !== 1'h1 && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		// A missing answer reads as unknown, so any compare of it fails
		got = n < 40 ? out_sample : 'x;
		// Keeps pairs well over 17 cycles apart
		repeat (20) @(posedge sys_clk);
	endtask : send
endmodule : source_switch_model

// ---- verification/test_effects_chain.sv ----
// Self-checking testbench for the audio effects chain
`timescale 1ns/1ps
module test_effects_chain;
	logic sys_clk, rst_n, cyc_i, stb_i, we_i, ack_o, sample_valid, out_valid;
	logic [11:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, rd;
	effects_pkg::stereo_t main_in, mix_in, out_sample, got;
	logic [31:0] main_v = 32'h1000F800;
	logic [31:0] mix_v = 32'h04000200;
	int fail_count, checks_done;

	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	effects_chain dut (.sys_clk(sys_clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.sample_valid(sample_valid), .main_in(main_in), .mix_in(mix_in),
		.out_sample(out_sample), .out_valid(out_valid));
	source_switch_model src (.sys_clk(sys_clk), .sample_valid(sample_valid), .main_in(main_in),
		.mix_in(mix_in), .out_sample(out_sample), .out_valid(out_valid));

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Classic single Wishbone cycle; read data lands in rd
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack_o !== 1'h1 && n < 50);
		chk("ack", 32'h1, {31'h0, ack_o});
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		we_i <= 1'h0;
	endtask : wb

	task automatic run(input string name, input logic [31:0] exp);
		src.send(main_v, mix_v, got);
		chk(name, exp, got);
	endtask : run

	task automatic stop_test;
		$display("TB: checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test

	// The sequence needs under 1500 cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		fail_count++;
		stop_test;
	end

	initial begin
		rst_n = 1'h0;
		cyc_i = 1'h0;
		stb_i = 1'h0;
		we_i = 1'h0;
		adr_i = 12'h000;
		sel_i = 4'h0;
		dat_i = 32'h0;
		fail_count = 0;
		checks_done = 0;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'h1;
		wb(1'h0, effects_pkg::REG_MIXER, 32'h0);
		chk("mixer reset", 32'h00000100, rd);
		wb(1'h0, effects_pkg::REG_GEQ_LO, 32'h0);
		chk("band gains", 32'h2F2F2F2F, rd);
		wb(1'h0, 12'h1C0, 32'h0);
		chk("last section b0", 32'h00020000, rd);
		wb(1'h1, 12'h300, 32'hFFFFFFFF);
		wb(1'h0, 12'h300, 32'h0);
		chk("unmapped", 32'h0, rd);
		run("chain off", 32'h0);
		wb(1'h1, effects_pkg::REG_MIXER, 32'h01000100);
		wb(1'h1, effects_pkg::REG_CTRL, 32'h003);
		run("mixer sum", 32'h1400FA00);
		wb(1'h1, effects_pkg::REG_CTRL, 32'h001);
		run("all bypass", main_v);
		wb(1'h1, effects_pkg::REG_MIXER, 32'h00000200);
		wb(1'h1, effects_pkg::REG_CTRL, 32'h003);
		run("double main", 32'h2000F000);
		wb(1'h1, effects_pkg::REG_MIXER, 32'h00000100);
		wb(1'h1, effects_pkg::REG_CTRL, 32'h081);
		run("flat parametric", main_v);
		wb(1'h1, effects_pkg::COEF_BASE, 32'h00010000);
		wb(1'h0, effects_pkg::COEF_BASE, 32'h0);
		chk("b0 readback", 32'h00010000, rd);
		run("half b0", 32'h0800FC00);
		wb(1'h1, effects_pkg::REG_CTRL, 32'h001);
		run("equalizer off", main_v);
		wb(1'h1, effects_pkg::REG_SHAPE, 32'h00204007);
		wb(1'h1, effects_pkg::REG_CTRL, 32'h045);
		run("wide surround", 32'h1A80ED80);
		wb(1'h1, effects_pkg::REG_SHAPE, 32'h00202000);
		wb(1'h1, effects_pkg::REG_CTRL, 32'h009);
		run("bass original level", 32'h0800FC00);
		wb(1'h1, effects_pkg::REG_ALC_THRESH, 32'h0000FFFF);
		wb(1'h1, effects_pkg::REG_CTRL, 32'h011);
		run("limiter below threshold", main_v);
		run("limiter holds unity", main_v);
		wb(1'h1, effects_pkg::REG_CTRL, 32'h101);
		run("tone half bass section", 32'h0800FC00);
		wb(1'h1, effects_pkg::REG_CTRL, 32'h181);
		run("graphic band sum", 32'h0E66F8CC);
		wb(1'h1, effects_pkg::REG_CTRL, 32'h000);
		run("chain off after audio", 32'h0);
		stop_test;
	end
endmodule : test_effects_chain
